/* acmp_pkg.sv */
// package of offsets, field positions and reset values for the comparator control block
// assumes a 32-bit avalon-mm word bus, one register per aligned word
package acmp_pkg;
    // printed offsets 0x03 and 0x08 are indices; byte address is four times the index
    localparam logic [7:0] IDX_CONV_B    = 8'h03;
    localparam logic [7:0] IDX_CMP_CS    = 8'h08;
    localparam logic [7:0] IDX_DIG_DIS   = 8'h09;
    localparam logic [7:0] IDX_CONV_A    = 8'h0A;
    localparam logic [7:0] IDX_CONV_MUX  = 8'h0B;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h0D;
    localparam logic [7:0] IDX_CPU_STAT  = 8'h0E;
    // control_b field layout
    localparam int         CB_MUX_EN     = 6;
    localparam logic [7:0] CB_WR_MASK    = 8'hD7;
    localparam logic [7:0] CB_RESET      = 8'h00;
    // control/status field layout
    localparam int         CS_DISABLE    = 7;
    localparam int         CS_BANDGAP    = 6;
    localparam int         CS_RESULT     = 5;
    localparam int         CS_FLAG       = 4;
    localparam int         CS_IRQ_EN     = 3;
    localparam int         CS_CAPTURE    = 2;
    localparam int         CS_MODE_HI    = 1;
    localparam int         CS_MODE_LO    = 0;
    localparam logic [7:0] CS_WR_MASK    = 8'hCF;
    localparam logic [7:0] CS_RESET      = 8'h00;
    localparam int         CONV_A_EN     = 7;
    localparam int         CPU_GIE       = 7;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [1:0] MODE_TOGGLE   = 2'h0;
    localparam logic [1:0] MODE_FALL     = 2'h2;
    localparam logic [1:0] MODE_RISE     = 2'h3;
    // wrapper status bits: 0 comparator event, 1 result change
    localparam int         ST_EVENT      = 0;
    localparam int         ST_CHANGE     = 1;
endpackage

/* acmp_ctrl.sv */
// comparator control: input select, result sync, event detect, interrupt, capture route
// assumes analog compare is modelled by the pos/neg voltage codes on input ports
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - result is high when selected positive input exceeds selected negative input
// - mux enabled and converter off: channel select picks channel pin 0 to 7
// - mux disabled or converter on: dedicated negative pin is used
// - bandgap select substitutes fixed reference for positive pin
// - raw compare output is synchronised, delay one to two clocks
// - event flag set when synced change matches selected event mode
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - comparator_irq requested only if flag, interrupt enable and global enable set
// - flag cleared on vector acknowledge or by writing one
// - disable bit powers comparator down, writable at any time
// - capture enable routes result to timer capture input, else none
// - input disable bits kill pin buffers, pin reads zero
// - control_b resets to zero, bits 5 and 3 read-only
// - converter enable bit gates multiplexer use
module acmp_ctrl
    import acmp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [9:0]  positive_input_pin,
    input  wire logic [9:0]  negative_input_pin,
    input  wire logic [79:0] analog_channel_pins,
    input  wire logic [9:0]  bandgap_level,
    input  wire logic [1:0]  pin_digital_in,
    input  wire logic        vector_ack,
    output logic      [1:0]  pin_digital_read,
    output logic             comparator_power_on,
    output logic      [1:0]  pin_buffer_enable,
    output logic             capture_trigger,
    output logic             comparator_irq,
    output logic             irq
);
    typedef struct packed {
        logic [7:0] conv_b;
        logic [7:0] cs;
        logic [7:0] dig_dis;
        logic [7:0] conv_a;
        logic [7:0] conv_mux;
        logic [7:0] cpu_stat;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic       raw_s1;
        logic       raw_s2;
        logic       res_prev;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic       ack_done;
        logic [31:0] rdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] msk);
        merge = (old & ~msk) | (wd & msk);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [9:0] neg_level;
    logic [9:0] pos_level;
    logic       raw_cmp;
    logic       result;
    logic       rise;
    logic       fall;
    logic       event_hit;
    logic       wr_en;
    logic [7:0] wd;
    logic [7:0] idx;

    always_comb begin
        // converter on blocks the mux path since its multiplexer is busy
        if (s_r.conv_b[CB_MUX_EN] && !s_r.conv_a[CONV_A_EN]) begin
            neg_level = analog_channel_pins[s_r.conv_mux[2:0]*10 +: 10];
        end else begin
            neg_level = negative_input_pin;
        end
    end

    assign pos_level = s_r.cs[CS_BANDGAP] ? bandgap_level : positive_input_pin;
    // powered-down comparator reads low
    assign raw_cmp   = !s_r.cs[CS_DISABLE] && (pos_level > neg_level);
    assign result    = s_r.raw_s2;
    assign rise      = result && !s_r.res_prev;
    assign fall      = !result && s_r.res_prev;

    always_comb begin
        unique case (s_r.cs[1:0])
            MODE_TOGGLE: event_hit = rise || fall;
            MODE_FALL:   event_hit = fall;
            MODE_RISE:   event_hit = rise;
            default:     event_hit = 1'b0;
        endcase
    end

    assign idx   = {2'h0, avs_address};
    assign wr_en = avs_write && avs_byteenable[0];
    assign wd    = avs_writedata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt          = s_r;
        s_nxt.raw_s1   = raw_cmp;
        s_nxt.raw_s2   = s_r.raw_s1;
        s_nxt.res_prev = result;
        s_nxt.pin_s1   = pin_digital_in;
        s_nxt.pin_s2   = s_r.pin_s1;
        s_nxt.ack_done = 1'b0;
        if (wr_en) begin
            unique case (idx)
                IDX_CONV_B:   s_nxt.conv_b   = merge(s_r.conv_b, wd, CB_WR_MASK);
                IDX_CMP_CS: begin
                    s_nxt.cs = merge(s_r.cs, wd, CS_WR_MASK);
                    if (wd[CS_FLAG]) begin
                        s_nxt.cs[CS_FLAG] = 1'b0;
                    end
                end
                IDX_DIG_DIS:  s_nxt.dig_dis  = wd;
                IDX_CONV_A:   s_nxt.conv_a   = wd;
                IDX_CONV_MUX: s_nxt.conv_mux = wd;
                IDX_CPU_STAT: s_nxt.cpu_stat = wd;
                IDX_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~wd[1:0];
                IDX_IRQ_MASK: s_nxt.irq_mask = wd[1:0];
                default:      ;
            endcase
        end
        if (vector_ack) begin
            s_nxt.cs[CS_FLAG] = 1'b0;
        end
        // set wins over any clear in the same cycle
        if (event_hit) begin
            s_nxt.cs[CS_FLAG]     = 1'b1;
            s_nxt.irq_stat[ST_EVENT] = 1'b1;
        end
        if (rise || fall) begin
            s_nxt.irq_stat[ST_CHANGE] = 1'b1;
        end
        s_nxt.rdata = 32'h0;
        if (avs_read) begin
            unique case (idx)
                IDX_CONV_B:   s_nxt.rdata[7:0] = s_r.conv_b;
                IDX_CMP_CS: begin
                    s_nxt.rdata[7:0]         = s_r.cs;
                    s_nxt.rdata[CS_RESULT]   = result;
                end
                IDX_DIG_DIS:  s_nxt.rdata[7:0] = s_r.dig_dis;
                IDX_CONV_A:   s_nxt.rdata[7:0] = s_r.conv_a;
                IDX_CONV_MUX: s_nxt.rdata[7:0] = s_r.conv_mux;
                IDX_CPU_STAT: s_nxt.rdata[7:0] = s_r.cpu_stat;
                IDX_IRQ_STAT: s_nxt.rdata[1:0] = s_r.irq_stat;
                IDX_IRQ_MASK: s_nxt.rdata[1:0] = s_r.irq_mask;
                default:      s_nxt.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle read latency: readdata registered, so wait one cycle on reads
    logic rd_pend_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= avs_read && !rd_pend_r;
        end
    end
    assign avs_waitrequest = avs_read && !rd_pend_r;
    assign avs_readdata    = s_r.rdata;

    assign comparator_power_on = !s_r.cs[CS_DISABLE];
    assign capture_trigger     = s_r.cs[CS_CAPTURE] && result;
    assign comparator_irq      = s_r.cs[CS_FLAG] && s_r.cs[CS_IRQ_EN]
                                 && s_r.cpu_stat[CPU_GIE];
    assign irq                 = |(s_r.irq_stat & s_r.irq_mask);
    assign pin_buffer_enable   = ~s_r.dig_dis[1:0];
    assign pin_digital_read    = s_r.pin_s2 & ~s_r.dig_dis[1:0];

    ////////////////////////////////////////////////////////////////////////////
    a_irq_gate: assert property (@(posedge clk) disable iff (rst)
        comparator_irq |-> s_r.cs[CS_FLAG] && s_r.cs[CS_IRQ_EN] && s_r.cpu_stat[CPU_GIE])
        else $error("irq without flag and enables");
    a_sync_delay: assert property (@(posedge clk) disable iff (rst)
        $changed(s_r.raw_s1) |=> result == $past(s_r.raw_s1))
        else $error("result not two flops after compare");
    a_rise_flag: assert property (@(posedge clk) disable iff (rst)
        (s_r.cs[1:0] == MODE_RISE && rise) |=> s_r.cs[CS_FLAG])
        else $error("rising event lost");
    a_fall_only: assert property (@(posedge clk) disable iff (rst)
        (s_r.cs[1:0] == MODE_FALL && rise && !s_r.cs[CS_FLAG] && !fall) |=> !s_r.cs[CS_FLAG])
        else $error("falling mode flagged on rise");
    a_ack_clear: assert property (@(posedge clk) disable iff (rst)
        (vector_ack && !event_hit) |=> !s_r.cs[CS_FLAG])
        else $error("flag survived vector");
    a_neg_mux: assert property (@(posedge clk) disable iff (rst)
        !s_r.conv_b[CB_MUX_EN] |-> neg_level == negative_input_pin)
        else $error("negative pin not selected");
    a_capture_off: assert property (@(posedge clk) disable iff (rst)
        !s_r.cs[CS_CAPTURE] |-> !capture_trigger)
        else $error("capture route without enable");
    a_pin_zero: assert property (@(posedge clk) disable iff (rst)
        s_r.dig_dis[0] |-> !pin_digital_read[0])
        else $error("disabled pin reads one");
    a_ro_bits: assert property (@(posedge clk) disable iff (rst)
        !s_r.conv_b[5] && !s_r.conv_b[3])
        else $error("read-only bits set");
    a_power_off: assert property (@(posedge clk) disable iff (rst)
        s_r.cs[CS_DISABLE] |-> !raw_cmp)
        else $error("disabled comparator drives high");
endmodule // acmp_ctrl

/* analog_front.sv */
// partner model: analog voltage codes at the comparator pins and raw digital pin levels
// assumes the bench calls the set tasks right after a rising edge of clk
`timescale 1ns/1ps
module analog_front (
    input  wire logic        clk,
    output logic      [9:0]  pos,
    output logic      [9:0]  neg,
    output logic      [9:0]  bg,
    output logic      [79:0] chans,
    output logic      [1:0]  dig
);
    initial begin
        pos = 10'h000;
        neg = 10'h000;
        bg = 10'h000;
        chans = 80'h0;
        dig = 2'h3;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // levels move only at a clock edge so the sync stage sees one clean step
    task automatic set(input logic [9:0] p, input logic [9:0] n, input logic [9:0] b);
        @(posedge clk);
        pos <= p;
        neg <= n;
        bg <= b;
    endtask
    task automatic chan(input int i, input logic [9:0] v);
        chans[i*10+:10] <= v;
    endtask
endmodule // analog_front

/* tb.sv */
// self-checking bench for the comparator control block
// assumes avalon word indices and two-edge compare latency from the package and notes
`timescale 1ns/1ps
module tb;
    import acmp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [9:0]  pos, neg, bg;
    logic [79:0] chans;
    logic [1:0]  dig, pin_rd, pin_buf;
    logic        vector_ack = 1'b0;
    logic        pwr, cap, cirq, irq;
    logic [7:0]  q;
    logic [1:0]  md;
    int          bad_count = 0;
    int          checked = 0;
    always #10 clk = ~clk;
    acmp_ctrl dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .positive_input_pin(pos), .negative_input_pin(neg), .analog_channel_pins(chans),
        .bandgap_level(bg), .pin_digital_in(dig), .vector_ack(vector_ack),
        .pin_digital_read(pin_rd), .comparator_power_on(pwr), .pin_buffer_enable(pin_buf),
        .capture_trigger(cap), .comparator_irq(cirq), .irq(irq));
    analog_front af (.clk(clk), .pos(pos), .neg(neg), .bg(bg), .chans(chans), .dig(dig));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    // one bus cycle; request held until the rising edge that sees waitrequest low
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= idx[5:0];
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            bad_count++;
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wt();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc(0, IDX_CONV_B, 8'h00); chk_reg("conv_b reset", CB_RESET, q);
        acc(0, IDX_CMP_CS, 8'h00); chk_reg("cs reset", CS_RESET, q);
        acc(1, IDX_CONV_B, 8'hFF); acc(0, IDX_CONV_B, 8'h00);
        chk_reg("conv_b ro bits", CB_WR_MASK, q);
        acc(1, 8'h3F, 8'hFF); acc(0, 8'h3F, 8'h00); chk_reg("unmapped", 8'h00, q);
        $display("test registers done");
        af.chan(7, 10'd50); af.chan(0, 10'd900); af.set(10'd500, 10'd600, 10'd50);
        acc(1, IDX_CONV_B, 8'h40); acc(1, IDX_CONV_MUX, 8'h07); wt();
        acc(0, IDX_CMP_CS, 8'h00); chk_pin("mux ch7", 1'b1, q[CS_RESULT]);
        acc(1, IDX_CONV_MUX, 8'h00); wt();
        acc(0, IDX_CMP_CS, 8'h00); chk_pin("mux ch0", 1'b0, q[CS_RESULT]);
        acc(1, IDX_CONV_MUX, 8'h07); acc(1, IDX_CONV_A, 8'h80); wt();
        acc(0, IDX_CMP_CS, 8'h00); chk_pin("conv on", 1'b0, q[CS_RESULT]);
        acc(1, IDX_CONV_A, 8'h00); acc(1, IDX_CONV_B, 8'h00); wt();
        acc(0, IDX_CMP_CS, 8'h00); chk_pin("mux off", 1'b0, q[CS_RESULT]);
        $display("test input select done");
        // interrupt enable stays off while the mode changes, as software must
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            af.set(10'd100, 10'd500, 10'd50); acc(1, IDX_CMP_CS, {6'h0, md}); wt();
            acc(1, IDX_CMP_CS, {6'h04, md}); acc(0, IDX_CMP_CS, 8'h00);
            chk_reg("flag cleared", {6'h0, md}, q);
            af.set(10'd500, 10'd100, 10'd50); wt(); acc(0, IDX_CMP_CS, 8'h00);
            chk_reg("rise", {3'b001, (md == 0 || md == 3), 2'b00, md}, q);
            acc(1, IDX_CMP_CS, {6'h04, md}); af.set(10'd100, 10'd500, 10'd50); wt();
            acc(0, IDX_CMP_CS, 8'h00);
            chk_reg("fall", {3'b000, (md == 0 || md == 2), 2'b00, md}, q);
        end
        $display("test event modes done");
        acc(1, IDX_CMP_CS, 8'h10); acc(1, IDX_CPU_STAT, 8'h80); acc(1, IDX_CMP_CS, 8'h08);
        wt(); chk_pin("irq idle", 1'b0, cirq);
        af.set(10'd500, 10'd100, 10'd50); wt(); chk_pin("irq raised", 1'b1, cirq);
        acc(1, IDX_CPU_STAT, 8'h00); wt(); chk_pin("gie off", 1'b0, cirq);
        acc(1, IDX_CPU_STAT, 8'h80); wt(); chk_pin("gie on", 1'b1, cirq);
        @(posedge clk) vector_ack <= 1'b1;
        @(posedge clk) vector_ack <= 1'b0;
        wt(); chk_pin("vector clear", 1'b0, cirq);
        chk_pin("wrap masked", 1'b0, irq);
        acc(1, IDX_IRQ_MASK, 8'h01); wt(); chk_pin("wrap irq", 1'b1, irq);
        acc(1, IDX_IRQ_STAT, 8'h03); wt(); chk_pin("wrap clear", 1'b0, irq);
        $display("test interrupts done");
        acc(1, IDX_CMP_CS, 8'h00); acc(1, IDX_CMP_CS, 8'h80); wt();
        chk_pin("power off", 1'b0, pwr);
        acc(1, IDX_CMP_CS, 8'h04); wt(); chk_pin("capture on", 1'b1, cap);
        acc(1, IDX_CMP_CS, 8'h00); wt(); chk_pin("capture off", 1'b0, cap);
        acc(1, IDX_CMP_CS, 8'h40); wt(); acc(0, IDX_CMP_CS, 8'h00);
        chk_pin("bandgap", 1'b0, q[CS_RESULT]);
        chk_reg("pins live", 8'h03, {6'h0, pin_rd});
        acc(1, IDX_DIG_DIS, 8'h03); wt();
        chk_reg("pins forced", 8'h00, {6'h0, pin_rd});
        chk_reg("buffers off", 8'h00, {6'h0, pin_buf});
        $display("test power capture pins done");
        end_sim();
    end
endmodule // tb
